// ==== osw_pkg.sv ====
`default_nettype none
package osw_pkg;
  // bus shape
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register word offsets
  localparam logic [3:0] OFS_FWD_SEL = 4'h0;
  localparam logic [3:0] OFS_REV_SEL = 4'h1;
  localparam logic [3:0] OFS_STOP_SEL = 4'h2;
  localparam logic [3:0] OFS_ESTOP_TQ = 4'h3;
  localparam logic [3:0] OFS_DECEL_MS = 4'h4;
  localparam logic [3:0] OFS_WARN_SEL = 4'h5;
  localparam logic [3:0] OFS_CTRL = 4'h6;
  localparam logic [3:0] OFS_STATUS = 4'h7;

  // reset (factory) values
  localparam logic [3:0] FWD_SEL_RST = 4'h2;
  localparam logic [3:0] REV_SEL_RST = 4'h3;
  localparam logic [7:0] STOP_SEL_RST = 8'h00;
  localparam logic [9:0] ESTOP_TQ_RST = 10'h320;
  localparam logic [13:0] DECEL_MS_RST = 14'h0000;
  localparam logic [3:0] WARN_SEL_RST = 4'h0;

  // setting codes and limits
  localparam logic [3:0] SEL_IGNORE = 4'h8;
  localparam logic [3:0] WARN_DETECT = 4'h1;
  localparam logic [9:0] ESTOP_TQ_MAX = 10'h320;
  localparam logic [13:0] DECEL_MS_MAX = 14'h2710;

  // control bit positions
  localparam int CTRL_SERVO_ON = 0;
  localparam int CTRL_MOVE = 1;
  localparam int CTRL_DIR_FWD = 2;
  localparam int CTRL_TORQUE = 3;
  localparam int CTRL_ALARM_CLEAR_COMMAND = 4;
  localparam int CTRL_RESTART = 5;

  // status bit positions
  localparam int ST_FWD_OT = 0;
  localparam int ST_REV_OT = 1;
  localparam int ST_WARN = 2;
  localparam int ST_ACT_LSB = 4;
  localparam int ST_HOLD_LSB = 8;
  localparam int ST_FSM_LSB = 12;

  // timing: one millisecond at the 25 MHz reference
  localparam int CLK_HZ = 25_000_000;
  localparam int MS_TIME_US = 1000;
  localparam int MS_CYCLES = CLK_HZ / 1_000_000 * MS_TIME_US;

  typedef enum logic [2:0] {
    ACT_NONE = 3'b000,
    ACT_DB = 3'b001,
    ACT_COAST = 3'b010,
    ACT_DEC_TQ = 3'b011,
    ACT_DEC_RAMP = 3'b100,
    ACT_ZERO_SPD = 3'b101
  } osw_act_t;

  typedef enum logic [1:0] {
    HOLD_NONE = 2'b00,
    HOLD_COAST = 2'b01,
    HOLD_ZERO = 2'b10
  } osw_hold_t;

  typedef enum logic [1:0] {
    FSM_RUN = 2'b00,
    FSM_STOP = 2'b01,
    FSM_HELD = 2'b10
  } osw_fsm_t;

  // lesser of configured torque and motor ceiling
  function automatic logic [9:0] osw_clip(input logic [9:0] a, input logic [9:0] b);
    return (a < b) ? a : b;
  endfunction : osw_clip
endpackage : osw_pkg
`default_nettype wire

// ==== osw_tick.sv ====
`timescale 1ns/1ns
`default_nettype none
module osw_tick import osw_pkg::*; #(
  parameter int CYCLES = MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  output logic tick
);
  logic [31:0] cnt_q;

  if (CYCLES < 2) begin : g_chk
    $error("osw_tick: CYCLES must be at least 2");
  end

  // free running millisecond strobe
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_q == 32'(CYCLES - 1));
      cnt_q <= (cnt_q == 32'(CYCLES - 1)) ? 32'h0 : cnt_q + 32'h1;
    end
  end

  a_tick_spacing: assert property (@(posedge ref_clk) disable iff (reset)
    tick |=> !tick) else $error("tick pulse lasted more than one cycle");
endmodule : osw_tick
`default_nettype wire

// ==== osw_ramp.sv ====
`timescale 1ns/1ns
`default_nettype none
module osw_ramp import osw_pkg::*; #(
  parameter int SPD_W = 16,
  parameter int TIME_W = 14
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [SPD_W-1:0] start_speed,
  input wire logic [SPD_W-1:0] max_speed,
  input wire logic [TIME_W-1:0] decel_ms,
  input wire logic ms_tick,
  output logic [SPD_W-1:0] speed_ref
);
  localparam int ACC_W = SPD_W + TIME_W + 1;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_sum;
  logic [ACC_W-1:0] span;
  logic step;

  // each ms adds max_speed worth of drop; at most one unit removed per clock, each costing decel_ms
  assign span = ACC_W'(decel_ms);
  assign acc_sum = acc_q + (ms_tick ? ACC_W'(max_speed) : '0);
  assign step = (speed_ref != '0) && (span != '0) && (acc_sum >= span);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      speed_ref <= '0;
      acc_q <= '0;
    end else if (start) begin
      speed_ref <= (decel_ms == '0) ? '0 : start_speed;
      acc_q <= '0;
    end else if (speed_ref == '0) begin
      acc_q <= '0;
    end else begin
      speed_ref <= step ? speed_ref - SPD_W'(1) : speed_ref;
      acc_q <= step ? acc_sum - span : acc_sum;
    end
  end

  a_zero_time_stop: assert property (@(posedge ref_clk) disable iff (reset)
    (start && decel_ms == '0) |=> speed_ref == '0) else $error("zero time did not stop");
endmodule : osw_ramp
`default_nettype wire

// ==== osw_overtravel.sv ====
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - forward limit honoured at 2, ignored at 8
// - reverse limit honoured at 3, ignored at 8
// - inactive limit input means overtravel that side
// - stop method digits choose stop and hold
// - torque control: brake or coast, then coast
// - torque deceleration capped by emergency stop torque
// - applied torque clipped to motor maximum
// - ramp time spans maximum speed to standstill
// - zero ramp time means zero-speed stop
// - warn on overtravel entry, only with servo on
// - warning detection enabled by low digit 1
// - warning never alters stop or commands
// - moving: warn only on command-side overtravel
// - idle: warn on either side
// - no warning at servo on during overtravel
// - warning holds until alarm clear command
// - after clear, rearm only once overtravel ends
// - soft limit does not block detection
module osw_overtravel import osw_pkg::*; #(
  parameter int MS_CYC = MS_CYCLES,
  parameter logic [15:0] MAX_SPEED = 16'h1770
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic forward_limit_input,
  input wire logic reverse_limit_input,
  input wire logic [15:0] motor_speed,
  input wire logic [9:0] motor_max_torque,
  output logic forward_ot,
  output logic reverse_ot,
  output osw_act_t stop_action,
  output osw_hold_t hold_state,
  output logic [9:0] decel_torque_limit,
  output logic [15:0] speed_ref,
  output logic overtravel_warning
);
  if (MAX_SPEED == 16'h0) begin : g_chk
    $error("osw_overtravel: MAX_SPEED must be nonzero");
  end
  // the ramp drops at most one speed unit per clock, so one
  // millisecond must hold at least MAX_SPEED clocks
  if (MS_CYC < int'(MAX_SPEED)) begin : g_rate_chk
    $error("osw_overtravel: MS_CYC too small for the ramp rate");
  end

  // written settings
  logic [3:0] fwd_sel_q, rev_sel_q, warn_sel_q;
  logic [7:0] stop_sel_q;
  logic [9:0] estop_tq_q;
  logic [13:0] decel_ms_q;
  // settings in force since the last power-up or restart
  logic [3:0] fwd_sel_a, rev_sel_a;
  logic [7:0] stop_sel_a;
  logic warn_en_a;
  logic load_pend_q;
  // host commands
  logic servo_on_command, move_q, dir_fwd_q, torque_mode_q;
  logic alarm_clear_command;
  // detection and stop state
  logic qual_q;
  osw_fsm_t fsm_q, fsm_d;
  osw_act_t act_d;
  osw_hold_t hold_d;
  logic ms_tick, ramp_start;
  logic [15:0] ramp_speed;

  // bus decode
  wire wr_fwd = reg_wr && reg_addr == OFS_FWD_SEL;
  wire wr_rev = reg_wr && reg_addr == OFS_REV_SEL;
  wire wr_stop = reg_wr && reg_addr == OFS_STOP_SEL;
  wire wr_tq = reg_wr && reg_addr == OFS_ESTOP_TQ;
  wire wr_dec = reg_wr && reg_addr == OFS_DECEL_MS;
  wire wr_warn = reg_wr && reg_addr == OFS_WARN_SEL;
  wire wr_ctrl = reg_wr && reg_addr == OFS_CTRL;
  // out-of-range figures saturate at the documented maximum
  wire [9:0] tq_in = (reg_wdata[9:0] > ESTOP_TQ_MAX) ? ESTOP_TQ_MAX : reg_wdata[9:0];
  wire [13:0] dec_in = (reg_wdata[13:0] > DECEL_MS_MAX) ? DECEL_MS_MAX : reg_wdata[13:0];

  // setting registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fwd_sel_q <= FWD_SEL_RST;
      rev_sel_q <= REV_SEL_RST;
      stop_sel_q <= STOP_SEL_RST;
      estop_tq_q <= ESTOP_TQ_RST;
      decel_ms_q <= DECEL_MS_RST;
      warn_sel_q <= WARN_SEL_RST;
    end else begin
      if (wr_fwd) fwd_sel_q <= reg_wdata[3:0];
      if (wr_rev) rev_sel_q <= reg_wdata[3:0];
      if (wr_stop) stop_sel_q <= reg_wdata[7:0];
      if (wr_tq) estop_tq_q <= tq_in;
      if (wr_dec) decel_ms_q <= dec_in;
      if (wr_warn) warn_sel_q <= reg_wdata[3:0];
    end
  end

  // selects copied once after reset release, or on a restart request
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      load_pend_q <= 1'b1;
      fwd_sel_a <= FWD_SEL_RST;
      rev_sel_a <= REV_SEL_RST;
      stop_sel_a <= STOP_SEL_RST;
      warn_en_a <= 1'b0;
    end else begin
      load_pend_q <= wr_ctrl && reg_wdata[CTRL_RESTART];
      if (load_pend_q) begin
        fwd_sel_a <= fwd_sel_q;
        rev_sel_a <= rev_sel_q;
        stop_sel_a <= stop_sel_q;
        warn_en_a <= (warn_sel_q == WARN_DETECT);
      end
    end
  end

  // command register; alarm clear is a one-cycle pulse
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      servo_on_command <= 1'b0;
      move_q <= 1'b0;
      dir_fwd_q <= 1'b0;
      torque_mode_q <= 1'b0;
      alarm_clear_command <= 1'b0;
    end else begin
      alarm_clear_command <= wr_ctrl && reg_wdata[CTRL_ALARM_CLEAR_COMMAND];
      if (wr_ctrl) begin
        servo_on_command <= reg_wdata[CTRL_SERVO_ON];
        move_q <= reg_wdata[CTRL_MOVE];
        dir_fwd_q <= reg_wdata[CTRL_DIR_FWD];
        torque_mode_q <= reg_wdata[CTRL_TORQUE];
      end
    end
  end

  // limit selection: only code 8 switches a side off
  wire fwd_ot_d = (fwd_sel_a != SEL_IGNORE) && !forward_limit_input;
  wire rev_ot_d = (rev_sel_a != SEL_IGNORE) && !reverse_limit_input;

  // warning qualifier follows the command direction while moving
  wire qual_d = move_q ? (dir_fwd_q ? forward_ot : reverse_ot)
                       : (forward_ot || reverse_ot);
  // edge only: servo turning on mid-overtravel, or a cleared warning
  // with overtravel still present, sees no new rise; soft limits
  // are not an input here, so they never mask detection
  wire warn_set = warn_en_a && servo_on_command && qual_d && !qual_q;
  wire warn_d = warn_set || (overtravel_warning && !alarm_clear_command);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      forward_ot <= 1'b0;
      reverse_ot <= 1'b0;
      qual_q <= 1'b0;
      overtravel_warning <= 1'b0;
    end else begin
      forward_ot <= fwd_ot_d;
      reverse_ot <= rev_ot_d;
      qual_q <= qual_d;
      overtravel_warning <= warn_d;
    end
  end

  // stop method decode; torque control has no decelerating stop
  wire [3:0] dec_dig = stop_sel_a[7:4];
  wire [3:0] low_dig = stop_sel_a[3:0];
  wire use_low = torque_mode_q || dec_dig == 4'h0 || dec_dig > 4'h4;
  wire ramp_sel = dec_dig == 4'h3 || dec_dig == 4'h4;
  wire zero_hold = dec_dig == 4'h1 || dec_dig == 4'h3;

  always_comb begin
    if (use_low) begin
      act_d = (low_dig == 4'h2) ? ACT_COAST : ACT_DB;
      hold_d = HOLD_COAST;
    end else begin
      act_d = ramp_sel ? ((decel_ms_q == 14'h0) ? ACT_ZERO_SPD : ACT_DEC_RAMP)
                       : ACT_DEC_TQ;
      hold_d = zero_hold ? HOLD_ZERO : HOLD_COAST;
    end
  end

  // the warning plays no part in stopping
  wire ot_trip = servo_on_command && (forward_ot || reverse_ot);
  wire stopped = (stop_action == ACT_DEC_RAMP || stop_action == ACT_ZERO_SPD)
                 ? (ramp_speed == 16'h0) : (motor_speed == 16'h0);
  assign ramp_start = fsm_q == FSM_RUN && ot_trip;

  // run / stopping / held
  always_comb begin
    case (fsm_q)
      FSM_RUN: fsm_d = ot_trip ? FSM_STOP : FSM_RUN;
      FSM_STOP: fsm_d = !ot_trip ? FSM_RUN : (stopped ? FSM_HELD : FSM_STOP);
      FSM_HELD: fsm_d = ot_trip ? FSM_HELD : FSM_RUN;
      default: fsm_d = FSM_RUN;
    endcase
  end

  // action is latched at the trip and held until the state machine returns to run
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fsm_q <= FSM_RUN;
      stop_action <= ACT_NONE;
      hold_state <= HOLD_NONE;
    end else begin
      fsm_q <= fsm_d;
      if (fsm_d == FSM_RUN) begin
        stop_action <= ACT_NONE;
        hold_state <= HOLD_NONE;
      end else if (ramp_start) begin
        stop_action <= act_d;
        hold_state <= hold_d;
      end
    end
  end

  // torque ceiling tracks settings live, also while no stop uses it
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      decel_torque_limit <= 10'h000;
      speed_ref <= 16'h0000;
    end else begin
      decel_torque_limit <= osw_clip(estop_tq_q, motor_max_torque);
      speed_ref <= (fsm_q == FSM_RUN) ? motor_speed : ramp_speed;
    end
  end

  osw_tick #(.CYCLES(MS_CYC)) u_tick (
    .ref_clk(ref_clk),
    .reset(reset),
    .tick(ms_tick)
  );

  osw_ramp #(.SPD_W(16), .TIME_W(14)) u_ramp (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(ramp_start),
    .start_speed(motor_speed),
    .max_speed(MAX_SPEED),
    .decel_ms(decel_ms_q),
    .ms_tick(ms_tick),
    .speed_ref(ramp_speed)
  );

  // status read mux; unmapped reads return zero
  wire [DATA_W-1:0] status_w = {2'b00, fsm_q, 2'b00, hold_state, 1'b0, stop_action,
                                1'b0, overtravel_warning, reverse_ot, forward_ot};
  wire [DATA_W-1:0] ctrl_w = {12'h000, torque_mode_q, dir_fwd_q, move_q, servo_on_command};
  wire [DATA_W-1:0] rd_mux =
    (reg_addr == OFS_FWD_SEL) ? {12'h000, fwd_sel_q} :
    (reg_addr == OFS_REV_SEL) ? {12'h000, rev_sel_q} :
    (reg_addr == OFS_STOP_SEL) ? {8'h00, stop_sel_q} :
    (reg_addr == OFS_ESTOP_TQ) ? {6'h00, estop_tq_q} :
    (reg_addr == OFS_DECEL_MS) ? {2'h0, decel_ms_q} :
    (reg_addr == OFS_WARN_SEL) ? {12'h000, warn_sel_q} :
    (reg_addr == OFS_CTRL) ? ctrl_w :
    (reg_addr == OFS_STATUS) ? status_w : 16'h0000;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) reg_rdata <= 16'h0000;
    else reg_rdata <= reg_rd ? rd_mux : 16'h0000;
  end

  // limit selection guards
  a_fwd_ignored: assert property (@(posedge ref_clk) disable iff (reset)
    (fwd_sel_a == SEL_IGNORE && $stable(fwd_sel_a)) |-> !forward_ot)
    else $error("forward limit not ignored");
  a_fwd_honoured: assert property (@(posedge ref_clk) disable iff (reset)
    (fwd_sel_a != SEL_IGNORE && !load_pend_q && !forward_limit_input) |=> forward_ot)
    else $error("forward overtravel missed");
  a_rev_ignored: assert property (@(posedge ref_clk) disable iff (reset)
    (rev_sel_a == SEL_IGNORE && !load_pend_q && !reverse_limit_input) |=> !reverse_ot)
    else $error("reverse limit not ignored");
  // warning guards
  a_warn_servo_off: assert property (@(posedge ref_clk) disable iff (reset)
    (!servo_on_command && !overtravel_warning) |=> !overtravel_warning)
    else $error("warning raised with servo off");
  a_warn_held: assert property (@(posedge ref_clk) disable iff (reset)
    (overtravel_warning && !alarm_clear_command) |=> overtravel_warning)
    else $error("warning dropped without clear");
  a_warn_cleared: assert property (@(posedge ref_clk) disable iff (reset)
    (alarm_clear_command && !warn_set) |=> !overtravel_warning)
    else $error("alarm clear ignored");
  a_edge_only_warn: assert property (@(posedge ref_clk) disable iff (reset)
    (qual_q && qual_d && !overtravel_warning) |=> !overtravel_warning)
    else $error("warning raised without a new overtravel");
  a_opposite_side: assert property (@(posedge ref_clk) disable iff (reset)
    (move_q && dir_fwd_q && !forward_ot && !overtravel_warning) |=> !overtravel_warning)
    else $error("warning for opposite side");
  // stop guards
  a_torque_clip: assert property (@(posedge ref_clk) disable iff (reset)
    1'b1 |=> (decel_torque_limit <= $past(motor_max_torque)
              && decel_torque_limit <= $past(estop_tq_q)))
    else $error("stop torque above ceiling");
  a_torque_mode: assert property (@(posedge ref_clk) disable iff (reset)
    (ramp_start && torque_mode_q) |=> (stop_action inside {ACT_DB, ACT_COAST}
                                       && hold_state == HOLD_COAST))
    else $error("decelerating stop under torque control");
  a_trip_stops: assert property (@(posedge ref_clk) disable iff (reset)
    (fsm_q == FSM_RUN && ot_trip) |=> (fsm_q == FSM_STOP && stop_action != ACT_NONE))
    else $error("overtravel did not start a stop");
endmodule : osw_overtravel
`default_nettype wire

// ==== osw_far_end.sv ====
`timescale 1ns/1ns
`default_nettype none
// limit switches and motor as the drive sees them
module osw_far_end (
  input wire logic fwd_trip,
  input wire logic rev_trip,
  input wire logic [15:0] speed_set,
  input wire logic [9:0] torque_cap,
  output logic forward_limit_input,
  output logic reverse_limit_input,
  output logic [15:0] motor_speed,
  output logic [9:0] motor_max_torque
);
  // normally closed contacts: a tripped switch opens and reads low
  assign forward_limit_input = !fwd_trip;
  assign reverse_limit_input = !rev_trip;
  // motor holds its speed; no load dynamics, so a ramp is judged on speed_ref alone
  assign motor_speed = speed_set;
  assign motor_max_torque = torque_cap;
endmodule : osw_far_end
`default_nettype wire

// ==== test_overtravel_stop_and_warning.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_overtravel_stop_and_warning import osw_pkg::*;;
  localparam int MSC = 20;
  typedef struct packed {
    logic [3:0] fs; logic [3:0] rs; logic [7:0] st; logic [13:0] dm; logic tq;
    logic ft; logic rt; logic fo; logic ro; logic [2:0] act; logic [1:0] hold;
  } osw_row_t;
  logic ref_clk, reset, reg_wr, reg_rd, fwd_trip, rev_trip;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_q;
  logic [15:0] speed_set, motor_speed, speed_ref;
  logic [9:0] torque_cap, motor_max_torque, decel_torque_limit;
  logic forward_limit_input, reverse_limit_input, forward_ot, reverse_ot, overtravel_warning;
  osw_act_t stop_action;
  osw_hold_t hold_state;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [15:0] rst_vals [6] = '{16'h0002, 16'h0003, 16'h0000, 16'h0320, 16'h0000, 16'h0000};
  // fs rs stop decel tq ft rt | fo ro action hold
  osw_row_t rows [12] = '{
    '{4'h2, 4'h3, 8'h00, 14'd0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, ACT_DB, HOLD_COAST},
    '{4'h2, 4'h3, 8'h01, 14'd0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, ACT_DB, HOLD_COAST},
    '{4'h2, 4'h3, 8'h02, 14'd0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, ACT_COAST, HOLD_COAST},
    '{4'h2, 4'h3, 8'h10, 14'd0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, ACT_DEC_TQ, HOLD_ZERO},
    '{4'h2, 4'h3, 8'h20, 14'd0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, ACT_DEC_TQ, HOLD_COAST},
    '{4'h2, 4'h3, 8'h30, 14'd100, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, ACT_DEC_RAMP, HOLD_ZERO},
    '{4'h2, 4'h3, 8'h30, 14'd0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, ACT_ZERO_SPD, HOLD_ZERO},
    '{4'h2, 4'h3, 8'h40, 14'd100, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, ACT_DEC_RAMP, HOLD_COAST},
    '{4'h2, 4'h3, 8'h12, 14'd0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, ACT_COAST, HOLD_COAST},
    '{4'h8, 4'h3, 8'h00, 14'd0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, ACT_NONE, HOLD_NONE},
    '{4'h2, 4'h8, 8'h00, 14'd0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, ACT_NONE, HOLD_NONE},
    '{4'h8, 4'h8, 8'h00, 14'd0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, ACT_NONE, HOLD_NONE}};

  osw_overtravel #(.MS_CYC(MSC), .MAX_SPEED(16'h0014)) uut (.ref_clk(ref_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .forward_limit_input(forward_limit_input),
    .reverse_limit_input(reverse_limit_input), .motor_speed(motor_speed),
    .motor_max_torque(motor_max_torque), .forward_ot(forward_ot), .reverse_ot(reverse_ot),
    .stop_action(stop_action), .hold_state(hold_state),
    .decel_torque_limit(decel_torque_limit), .speed_ref(speed_ref),
    .overtravel_warning(overtravel_warning));
  osw_far_end far (.fwd_trip(fwd_trip), .rev_trip(rev_trip), .speed_set(speed_set),
    .torque_cap(torque_cap), .forward_limit_input(forward_limit_input),
    .reverse_limit_input(reverse_limit_input), .motor_speed(motor_speed),
    .motor_max_torque(motor_max_torque));

  // 25 MHz reference
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic print_verdict;
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // hang guard, well above the longest sequence
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // bus master: strobes launched and dropped right after a rising edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask : rd

  task automatic trip(input logic f, input logic r);
    @(posedge ref_clk);
    fwd_trip <= f;
    rev_trip <= r;
  endtask : trip

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  // selects only land after a restart, so each row reloads them
  task automatic setup(input logic [3:0] fs, input logic [7:0] st, input logic [15:0] ws);
    wr(OFS_FWD_SEL, {12'h000, fs});
    wr(OFS_STOP_SEL, {8'h00, st});
    wr(OFS_WARN_SEL, ws);
    wr(OFS_CTRL, 16'h0020);
  endtask : setup

  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    fwd_trip = 1'b0;
    rev_trip = 1'b0;
    speed_set = 16'd1000;
    torque_cap = 10'd300;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    // stop method table
    foreach (rows[i]) begin
      trip(1'b0, 1'b0);
      wr(OFS_CTRL, 16'h0000);
      wr(OFS_REV_SEL, {12'h000, rows[i].rs});
      wr(OFS_DECEL_MS, {2'b00, rows[i].dm});
      setup(rows[i].fs, rows[i].st, 16'h0000);
      wr(OFS_CTRL, {12'h000, rows[i].tq, 3'b001});
      trip(rows[i].ft, rows[i].rt);
      cyc(3);
      check("fwd_ot", {15'h0, forward_ot}, {15'h0, rows[i].fo});
      check("rev_ot", {15'h0, reverse_ot}, {15'h0, rows[i].ro});
      check("action", {13'h0, stop_action}, {13'h0, rows[i].act});
      check("hold", {14'h0, hold_state}, {14'h0, rows[i].hold});
      rd(OFS_STATUS);
      check("status", rd_q & 16'h0373,
        {6'h00, rows[i].hold, 1'b0, rows[i].act, 2'b00, rows[i].ro, rows[i].fo});
    end
    // reset values, unmapped place, one-cycle read data
    trip(1'b0, 1'b0);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    for (int a = 0; a < 6; a++) begin
      rd(a[3:0]);
      check("reset value", rd_q, rst_vals[a]);
    end
    rd(OFS_ESTOP_TQ);
    cyc(1);
    check("rdata after", reg_rdata, 16'h0000);
    wr(4'h9, 16'h1234);
    rd(4'h9);
    check("unmapped", rd_q, 16'h0000);
    // torque ceiling and clip to motor maximum
    wr(OFS_ESTOP_TQ, 16'h03ff);
    rd(OFS_ESTOP_TQ);
    check("torque sat", rd_q, 16'h0320);
    cyc(2);
    check("torque clip", {6'h00, decel_torque_limit}, 16'd300);
    wr(OFS_ESTOP_TQ, 16'h00c8);
    cyc(2);
    check("torque live", {6'h00, decel_torque_limit}, 16'd200);
    wr(OFS_DECEL_MS, 16'h3fff);
    rd(OFS_DECEL_MS);
    check("decel sat", rd_q, 16'h2710);
    // ramp of 4 ms from top speed
    wr(OFS_DECEL_MS, 16'h0004);
    setup(4'h2, 8'h30, 16'h0000);
    wr(OFS_CTRL, 16'h0001);
    speed_set <= 16'h0014;
    trip(1'b1, 1'b0);
    cyc(2 * MSC + 2);
    check("ramp mid", {15'h0, speed_ref > 16'h0004 && speed_ref < 16'h0012}, 16'h1);
    cyc(4 * MSC);
    check("ramp end", speed_ref, 16'h0000);
    rd(OFS_STATUS);
    check("held", {14'h0, rd_q[13:12]}, 16'h0002);
    // warning: servo off first
    trip(1'b0, 1'b0);
    wr(OFS_CTRL, 16'h0000);
    setup(4'h2, 8'h00, 16'h0001);
    trip(1'b1, 1'b0);
    cyc(3);
    check("warn servo off", {15'h0, overtravel_warning}, 16'h0);
    trip(1'b0, 1'b0);
    wr(OFS_CTRL, 16'h0001);
    cyc(50 * MSC + 1);
    trip(1'b1, 1'b0);
    cyc(1);
    check("warn early", {15'h0, overtravel_warning}, 16'h0);
    cyc(1);
    check("warn idle", {15'h0, overtravel_warning}, 16'h1);
    cyc(1);
    check("stop kept", {13'h0, stop_action}, {13'h0, ACT_DB});
    wr(OFS_CTRL, 16'h0007);
    rd(OFS_CTRL);
    check("cmd taken", rd_q, 16'h0007);
    trip(1'b0, 1'b0);
    wr(OFS_CTRL, 16'h0000);
    cyc(3);
    check("warn sticky", {15'h0, overtravel_warning}, 16'h1);
    wr(OFS_CTRL, 16'h0010);
    cyc(3);
    check("warn clear", {15'h0, overtravel_warning}, 16'h0);
    trip(1'b1, 1'b0);
    wr(OFS_CTRL, 16'h0001);
    cyc(4);
    check("servo on in ot", {15'h0, overtravel_warning}, 16'h0);
    trip(1'b0, 1'b0);
    trip(1'b1, 1'b0);
    cyc(2);
    check("rearm", {15'h0, overtravel_warning}, 16'h1);
    wr(OFS_CTRL, 16'h0011);
    cyc(4);
    check("clear in ot", {15'h0, overtravel_warning}, 16'h0);
    trip(1'b0, 1'b0);
    trip(1'b1, 1'b0);
    cyc(2);
    check("rearm again", {15'h0, overtravel_warning}, 16'h1);
    trip(1'b0, 1'b0);
    wr(OFS_CTRL, 16'h0017);
    trip(1'b0, 1'b1);
    cyc(3);
    check("opposite side", {15'h0, overtravel_warning}, 16'h0);
    trip(1'b1, 1'b1);
    cyc(2);
    check("same side", {15'h0, overtravel_warning}, 16'h1);
    print_verdict();
  end
endmodule : test_overtravel_stop_and_warning
`default_nettype wire
